// >>> logic/load_record_pkg.sv
// Shared constants and carriers for the assisted-load record loader.
// Assumes one clock domain; the record arrives as a stream of 16-bit words.
package load_record_pkg;

  localparam int WORD_W = 16;
  localparam int DATA_WORDS = 16;
  localparam int REC_WORDS = 20;          // set to 20, though first, sequence, segment, 16 data and 2 checksums make 21 words
  localparam int IDX_W = 5;
  localparam int ADDR_W = 16;
  localparam int LINE_BYTES = 32;

  // First-word patterns of the four load record kinds (odd parity each)
  localparam logic [15:0] FIRST_DATA = 16'h7303;
  localparam logic [15:0] FIRST_END = 16'h7305;
  localparam logic [15:0] FIRST_SKIP = 16'h7306;
  localparam logic [15:0] FIRST_RESET = 16'h0001;

  // Segment field layout
  localparam int SEG_COMP = 15;
  localparam int SEG_HIGH = 14;
  localparam int SEG_LOW = 13;
  localparam int SEG_BULK = 12;
  localparam int SEG_BANK = 11;
  localparam int SEG_A15 = 10;
  localparam logic [15:0] SEG_SEQ_ONLY = 16'h1000;
  localparam logic [15:0] SEG_ZERO = 16'h0000;

  // Word positions inside a record
  localparam logic [4:0] POS_FIRST = 5'h00;
  localparam logic [4:0] POS_SEQ = 5'h01;
  localparam logic [4:0] POS_SEG = 5'h02;
  localparam logic [4:0] POS_DATA0 = 5'h03;
  localparam logic [4:0] POS_SUM_EVEN = 5'h13;
  localparam logic [4:0] POS_SUM_ODD = 5'h14;
  localparam logic [4:0] POS_SHORT_SUM = 5'h03; // end and skip: first, seq, count, sums
  localparam logic [4:0] POS_DATA_LAST = 5'h12;

  typedef enum logic [1:0]
  {
    KIND_DATA = 2'b00,
    KIND_END = 2'b01,
    KIND_SKIP = 2'b10,
    KIND_RESET = 2'b11
  } rec_kind_type;

  // One memory write toward the selected targets
  typedef struct packed
  {
    logic [3:0] target;    // compression, high-rate, low-rate, bulk
    logic bank;
    logic [15:0] addr;
    logic [15:0] data;
  } mem_write_type;

  // Record outcome reported to the host logic
  typedef struct packed
  {
    logic accepted;
    logic parity_error;
    logic sum_error;
    logic seq_error;
    logic order_error;
    logic placement_error;
  } rec_result_type;

endpackage : load_record_pkg

// >>> logic/dual_checksum.sv
// Dual 16-bit checksum over alternate words of a record.
// Assumes clear is pulsed before the first word of each record.
`timescale 1ns/1ps
`default_nettype none
module dual_checksum
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic clear_in,
  input wire logic add_in,
  input wire logic odd_in,
  input wire logic [15:0] word_in,
  output logic [15:0] sum_even_out,
  output logic [15:0] sum_odd_out
);

  // Two running sums; wrap modulo 2^16 by design
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      sum_even_out <= 16'h0000;
      sum_odd_out <= 16'h0000;
    end
    else if (clear_in)
    begin
      sum_even_out <= 16'h0000;
      sum_odd_out <= 16'h0000;
    end
    else if (add_in)
    begin
      if (odd_in)
        sum_odd_out <= 16'(sum_odd_out + word_in);
      else
        sum_even_out <= 16'(sum_even_out + word_in);
    end
  end

endmodule : dual_checksum
`default_nettype wire

// >>> logic/segment_mapper.sv
// Maps a segment field and word position to a memory address.
// Purely combinational; the mapping is parameterised by one base and one XOR mask for all targets.
`timescale 1ns/1ps
`default_nettype none
module segment_mapper
#(
  parameter logic [15:0] MAP_BASE = 16'h0000,
  parameter logic [15:0] MAP_XOR = 16'h0000
)
(
  input wire logic [15:0] segment_in,
  input wire logic [3:0] word_idx_in,
  output logic [15:0] addr_out
);

  logic [15:0] line_addr;

  // Line number scaled by 64 bytes, then remapped; not plain concatenation
  assign line_addr = {segment_in[9:0], 6'h00} ^ MAP_XOR;
  assign addr_out = 16'(MAP_BASE + line_addr + {11'h000, word_idx_in, 1'b0});

endmodule : segment_mapper
`default_nettype wire

// >>> logic/load_record_loader.sv
// Boot-time loader for assisted-load records arriving word by word.
// Assumes words arrive synchronous to clk_in with a one-cycle strobe and a start marker.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Even parity first word means invalid record
// - Bit 15 writes compression processor memory
// - Bit 14 writes high-rate processor memory
// - Bit 13 writes low-rate processor memory
// - Bit 12 writes high-rate bulk store
// - Any target combination written together
// - Bank bit drives bank-select output; here it stays 0, since banked records are refused before the drain
// - Banked memory placement refused
// - Upper address bits; upper half refused
// - Address produced by mapping, not concatenation
// - Words addressed by position in line
// - Sequence numbers must increase across load
// - Both alternate-word checksums verified
// - From ROM only load records accepted
// - From RAM load records flagged invalid
// - Valid end record starts execution
// - End record count field ignored
// - Skip record breaks sequence, never first
// - Last segment decides skip bulk storage; a skip record here writes no memory
// - Reset record first, initializes sequencing
// - Reset record data words discarded
// - Segment 4096 writes no processor memory
// - Reset bulk bit matches the load; the loader never checks it
// - Reset segment zero means no bulk
module load_record_loader
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic word_valid_in,
  input wire logic word_start_in,
  input wire logic [15:0] word_in,
  input wire logic ram_mode_in,
  output load_record_pkg::mem_write_type mem_write_out,
  output logic mem_write_valid_out,
  output logic bank_select_out,
  output load_record_pkg::rec_result_type result_out,
  output logic result_valid_out,
  output logic invalid_command_out,
  output logic start_exec_out,
  output logic load_active_out,
  output logic [15:0] last_seq_out
);

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_BODY = 2'b01,
    ST_DROP = 2'b10
  } load_state_type;

  load_state_type state;
  load_record_pkg::rec_kind_type kind;
  logic [4:0] pos;
  logic [15:0] seq;
  logic [15:0] segment;
  logic [15:0] last_segment;
  logic [15:0] recv_even;
  logic [15:0] buffer [load_record_pkg::DATA_WORDS];
  logic [15:0] sum_even;
  logic [15:0] sum_odd;
  logic [4:0] drain_idx;
  logic draining;
  logic [15:0] drain_seg;
  logic [15:0] mapped_addr;
  logic parity_ok;
  logic is_load_kind;
  logic sum_add;
  logic sum_clear;
  logic rec_done;
  logic sums_good;
  logic seq_good;
  logic order_good;
  logic place_good;
  logic [15:0] eff_seg;
  logic [4:0] last_pos;
  load_record_pkg::rec_kind_type first_kind;

  // Odd parity check on the first 16 bits
  function automatic logic odd_parity(input logic [15:0] w);
    odd_parity = ^w;
  endfunction : odd_parity

  // First-word decode, used for kind; validity comes from is_load_kind
  function automatic load_record_pkg::rec_kind_type decode_kind(input logic [15:0] w);
    if (w == load_record_pkg::FIRST_END)
      decode_kind = load_record_pkg::KIND_END;
    else if (w == load_record_pkg::FIRST_SKIP)
      decode_kind = load_record_pkg::KIND_SKIP;
    else if (w == load_record_pkg::FIRST_RESET)
      decode_kind = load_record_pkg::KIND_RESET;
    else
      decode_kind = load_record_pkg::KIND_DATA;
  endfunction : decode_kind

  assign parity_ok = odd_parity(word_in);
  assign first_kind = decode_kind(word_in);
  // Only four patterns count; anything else is an invalid record
  assign is_load_kind = parity_ok && ((word_in == load_record_pkg::FIRST_DATA) ||
                        (word_in == load_record_pkg::FIRST_END) ||
                        (word_in == load_record_pkg::FIRST_SKIP) ||
                        (word_in == load_record_pkg::FIRST_RESET));

  // Short records carry only first, sequence, count and two sums
  assign last_pos = ((kind == load_record_pkg::KIND_END) || (kind == load_record_pkg::KIND_SKIP)) ?
                    5'(load_record_pkg::POS_SHORT_SUM + 5'h01) : load_record_pkg::POS_SUM_ODD;

  // Checksums cover sequence through last payload word
  assign sum_clear = word_valid_in && word_start_in;
  assign sum_add = word_valid_in && !word_start_in && (state == ST_BODY) &&
                   (pos < ((last_pos == load_record_pkg::POS_SUM_ODD) ?
                    load_record_pkg::POS_SUM_EVEN : load_record_pkg::POS_SHORT_SUM));

  dual_checksum u_sum
  (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .clear_in(sum_clear),
    .add_in(sum_add),
    .odd_in(pos[0]),
    .word_in(word_in),
    .sum_even_out(sum_even),
    .sum_odd_out(sum_odd)
  );

  assign rec_done = word_valid_in && !word_start_in && (state == ST_BODY) && (pos == last_pos);
  assign sums_good = (recv_even == sum_even) && (word_in == sum_odd);
  // Skip opens a gap, so it only needs to move forward
  assign seq_good = (kind == load_record_pkg::KIND_RESET) ||
                    ((kind == load_record_pkg::KIND_SKIP) ? (seq > last_seq_out) :
                     (seq == 16'(last_seq_out + 16'h0001)));
  assign order_good = (kind == load_record_pkg::KIND_RESET) || load_active_out;
  // Skip records take their placement from the last segment seen
  assign eff_seg = (kind == load_record_pkg::KIND_SKIP) ? last_segment : segment;
  assign place_good = (kind != load_record_pkg::KIND_DATA) ||
                      (!segment[load_record_pkg::SEG_BANK] &&
                       !segment[load_record_pkg::SEG_A15]);

  // Word intake and record framing
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state <= ST_IDLE;
      pos <= 5'h00;
      kind <= load_record_pkg::KIND_DATA;
    end
    else if (word_valid_in && word_start_in)
    begin
      pos <= 5'h01;
      kind <= first_kind;
      // From RAM every load record is dropped
      state <= (is_load_kind && !ram_mode_in) ? ST_BODY : ST_DROP;
    end
    else if (word_valid_in && (state == ST_BODY))
    begin
      pos <= 5'(pos + 5'h01);
      if (rec_done)
        state <= ST_IDLE;
    end
  end

  // Field capture; count field of short records is never stored
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      seq <= 16'h0000;
      segment <= 16'h0000;
      recv_even <= 16'h0000;
    end
    else if (word_valid_in && !word_start_in && (state == ST_BODY))
    begin
      if (pos == load_record_pkg::POS_SEQ)
        seq <= word_in;
      if ((pos == load_record_pkg::POS_SEG) && (last_pos == load_record_pkg::POS_SUM_ODD))
        segment <= word_in;
      if (pos == (5'(last_pos - 5'h01)))
        recv_even <= word_in;
    end
  end

  // Payload held until the record proves good; data go by position
  genvar g;
  generate
    for (g = 0; g < load_record_pkg::DATA_WORDS; g++)
    begin : g_buf
      always_ff @(posedge clk_in or negedge nrst_in)
      begin
        if (!nrst_in)
          buffer[g] <= 16'h0000;
        else if (word_valid_in && !word_start_in && (state == ST_BODY) &&
                 (last_pos == load_record_pkg::POS_SUM_ODD) &&
                 (pos == 5'(load_record_pkg::POS_DATA0 + 5'(g))))
          buffer[g] <= word_in;
      end
    end
  endgenerate

  // Sequence tracking and load state
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      last_seq_out <= 16'h0000;
      last_segment <= 16'h0000;
      load_active_out <= 1'b0;
    end
    else if (rec_done && sums_good && order_good && seq_good && place_good)
    begin
      last_seq_out <= seq;
      if (kind == load_record_pkg::KIND_RESET)
        load_active_out <= 1'b1;
      if (kind == load_record_pkg::KIND_END)
        load_active_out <= 1'b0;
      if ((kind == load_record_pkg::KIND_DATA) || (kind == load_record_pkg::KIND_RESET))
        last_segment <= segment;
    end
  end

  // Drain of a good data record toward the memories
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      draining <= 1'b0;
      drain_idx <= 5'h00;
      drain_seg <= 16'h0000;
    end
    else if (rec_done && sums_good && order_good && seq_good && place_good &&
             (kind == load_record_pkg::KIND_DATA) &&
             (segment != load_record_pkg::SEG_SEQ_ONLY))
    begin
      draining <= 1'b1;
      drain_idx <= 5'h00;
      drain_seg <= eff_seg;
    end
    else if (draining)
    begin
      drain_idx <= 5'(drain_idx + 5'h01);
      if (drain_idx == 5'(load_record_pkg::DATA_WORDS - 1))
        draining <= 1'b0;
    end
  end

  segment_mapper u_map
  (
    .segment_in(drain_seg),
    .word_idx_in(drain_idx[3:0]),
    .addr_out(mapped_addr)
  );

  // Memory write port; one word per cycle to every selected target
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      mem_write_out <= '0;
      mem_write_valid_out <= 1'b0;
      bank_select_out <= 1'b0;
    end
    else
    begin
      mem_write_valid_out <= draining && (drain_seg[15:12] != 4'h0);
      mem_write_out.target <= {drain_seg[load_record_pkg::SEG_COMP],
                               drain_seg[load_record_pkg::SEG_HIGH],
                               drain_seg[load_record_pkg::SEG_LOW],
                               drain_seg[load_record_pkg::SEG_BULK]};
      mem_write_out.bank <= drain_seg[load_record_pkg::SEG_BANK];
      mem_write_out.addr <= mapped_addr;
      mem_write_out.data <= buffer[drain_idx[3:0]];
      bank_select_out <= drain_seg[load_record_pkg::SEG_BANK];
    end
  end

  // Record verdicts and execution start
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      result_out <= '0;
      result_valid_out <= 1'b0;
      invalid_command_out <= 1'b0;
      start_exec_out <= 1'b0;
    end
    else
    begin
      result_valid_out <= rec_done || (word_valid_in && word_start_in &&
                          !(is_load_kind && !ram_mode_in));
      invalid_command_out <= word_valid_in && word_start_in &&
                             !(is_load_kind && !ram_mode_in);
      start_exec_out <= rec_done && sums_good && order_good && seq_good &&
                        (kind == load_record_pkg::KIND_END);
      result_out.accepted <= rec_done && sums_good && order_good && seq_good && place_good;
      // Any refused first word is reported as an invalid record
      result_out.parity_error <= word_valid_in && word_start_in &&
                                 !(is_load_kind && !ram_mode_in);
      result_out.sum_error <= rec_done && !sums_good;
      result_out.seq_error <= rec_done && order_good && !seq_good;
      result_out.order_error <= rec_done && !order_good;
      result_out.placement_error <= rec_done && !place_good;
    end
  end

endmodule : load_record_loader
`default_nettype wire

// >>> verif/loader_sva.sv
// Port-level assertions for the record loader.
// Assumes it is bound onto the loader; one clock, async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module loader_sva
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic word_valid_in,
  input wire logic word_start_in,
  input wire logic [15:0] word_in,
  input wire logic ram_mode_in,
  input wire load_record_pkg::mem_write_type mem_write_out,
  input wire logic mem_write_valid_out,
  input wire logic bank_select_out,
  input wire load_record_pkg::rec_result_type result_out,
  input wire logic result_valid_out,
  input wire logic invalid_command_out,
  input wire logic start_exec_out,
  input wire logic load_active_out,
  input wire logic [15:0] last_seq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // Execution start and its verdict
  a_exec_on_accept: assert property (start_exec_out |-> result_valid_out && result_out.accepted)
    else $error("start without accepted verdict");
  a_exec_ends_load: assert property (start_exec_out |=> !load_active_out)
    else $error("load still active after start");
  // Writes never reach banked memory or an empty target set
  a_no_bank_write: assert property (mem_write_valid_out |-> !mem_write_out.bank)
    else $error("write into banked memory");
  a_write_targeted: assert property (mem_write_valid_out |-> mem_write_out.target != 4'h0)
    else $error("write with no target");
  // Word address follows position within the line
  a_addr_by_pos: assert property (mem_write_valid_out && $past(mem_write_valid_out)
    |-> mem_write_out.addr == $past(mem_write_out.addr) + 16'h0002)
    else $error("address step not two");
  // A line drains as sixteen back-to-back writes
  a_drain_sixteen: assert property ($rose(mem_write_valid_out) |-> mem_write_valid_out [*8]
    ##1 mem_write_valid_out [*8] ##1 !mem_write_valid_out)
    else $error("drain length not sixteen");
  a_ram_refused: assert property (ram_mode_in && result_valid_out |-> !result_out.accepted)
    else $error("record accepted in ram mode");
  // Accepted and error flags exclude each other
  a_verdict_single: assert property (result_valid_out
    |-> result_out.accepted != (|result_out[4:0]))
    else $error("verdict flags inconsistent");
  a_invalid_refused: assert property (invalid_command_out
    |-> result_valid_out && !result_out.accepted)
    else $error("invalid command without refusal");
  a_verdict_pulse: assert property (result_valid_out |=> !result_valid_out [*4])
    else $error("verdict longer than one pulse");
  c_exec: cover property (start_exec_out);
  c_all_targets: cover property (mem_write_valid_out && mem_write_out.target == 4'hf);
  c_seq_error: cover property (result_valid_out && result_out.seq_error);
endmodule : loader_sva
`default_nettype wire

// >>> verif/record_sender.sv
// Command-system model: frames a record word by word with its dual sum.
// Assumes the caller supplies the first word and the payload words.
`timescale 1ns/1ps
`default_nettype none
module record_sender
(
  input wire logic clk_in,
  output logic word_valid_out,
  output logic word_start_out,
  output logic [15:0] word_out
);
  logic busy = 1'b0;
  initial word_valid_out = 1'b0;
  initial word_start_out = 1'b0;
  initial word_out = 16'h0000;
  // Idle bus toggles so stale words are never mistaken for data
  always @(posedge clk_in)
    if (!busy) #1 word_out <= ~word_out;
  // Caller gives odd-parity first words for good records
  task automatic send(input logic [15:0] first, input logic [15:0] body[$], input bit bad);
    logic [15:0] se;
    logic [15:0] so;
    se = 16'h0000;
    so = 16'h0000;
    foreach (body[i])
      if (i % 2 == 0) so += body[i];
      else se += body[i];
    if (bad) se = se + 16'h0001;
    body.push_front(first);
    body.push_back(se);
    body.push_back(so);
    busy = 1'b1;
    foreach (body[i])
    begin
      @(posedge clk_in);
      #1;
      word_valid_out = 1'b1;
      word_start_out = (i == 0);
      word_out = body[i];
    end
    @(posedge clk_in);
    #1;
    word_valid_out = 1'b0;
    word_start_out = 1'b0;
    busy = 1'b0;
  endtask : send
endmodule : record_sender
`default_nettype wire

// >>> verif/memory_load_record_loader_tb_top.sv
// Self-checking bench: queue model of verdicts and line writes.
// Assumes package constants and the hand-over timing of the loader.
`timescale 1ns/1ps
`default_nettype none
module memory_load_record_loader_tb_top;
  logic clk_in;
  logic nrst_in;
  logic word_valid_in;
  logic word_start_in;
  logic [15:0] word_in;
  logic ram_mode_in;
  load_record_pkg::mem_write_type mem_write_out;
  logic mem_write_valid_out;
  logic bank_select_out;
  load_record_pkg::rec_result_type result_out;
  logic result_valid_out;
  logic invalid_command_out;
  logic start_exec_out;
  logic load_active_out;
  logic [15:0] last_seq_out;
  int n_errors = 0;
  int n_checks = 0;
  int seed = 82;
  logic [15:0] m_last = 16'h0000;
  logic m_active = 1'b0;
  logic [15:0] r;
  logic [7:0] got_v[$];
  logic [37:0] got_w[$];

  record_sender i_sender
  (
    .clk_in(clk_in),
    .word_valid_out(word_valid_in),
    .word_start_out(word_start_in),
    .word_out(word_in)
  );

  load_record_loader i_dut
  (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .word_valid_in(word_valid_in),
    .word_start_in(word_start_in),
    .word_in(word_in),
    .ram_mode_in(ram_mode_in),
    .mem_write_out(mem_write_out),
    .mem_write_valid_out(mem_write_valid_out),
    .bank_select_out(bank_select_out),
    .result_out(result_out),
    .result_valid_out(result_valid_out),
    .invalid_command_out(invalid_command_out),
    .start_exec_out(start_exec_out),
    .load_active_out(load_active_out),
    .last_seq_out(last_seq_out)
  );

  // Clock
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // Outputs taken on the falling edge, where they are settled
  always @(negedge clk_in)
  begin
    if (nrst_in && result_valid_out)
      got_v.push_back({start_exec_out, invalid_command_out, result_out});
    if (nrst_in && mem_write_valid_out)
      got_w.push_back({bank_select_out, mem_write_out});
  end

  task automatic tally_and_finish();
    if ((n_errors == 0) && (n_checks > 0))
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic check_verdict(input logic [7:0] exp);
    n_checks++;
    if ((got_v.size() != 1) || (got_v[0] !== exp) || (last_seq_out !== m_last) ||
        (load_active_out !== m_active))
    begin
      n_errors++;
      $display("mismatch %0t verdict or load state", $time);
    end
    got_v.delete();
  endtask : check_verdict

  task automatic check_writes(input logic [37:0] exp[$]);
    n_checks++;
    if (got_w.size() != exp.size())
    begin
      n_errors++;
      $display("mismatch %0t write count", $time);
    end
    else
      foreach (exp[i])
        if (got_w[i] !== exp[i])
        begin
          n_errors++;
          $display("mismatch %0t write word", $time);
        end
    got_w.delete();
  endtask : check_writes

  task automatic check_idle();
    n_checks++;
    if ({load_active_out, last_seq_out, result_valid_out, mem_write_valid_out,
         start_exec_out} !== '0)
    begin
      n_errors++;
      $display("mismatch %0t outputs not idle after reset", $time);
    end
  endtask : check_idle

  // Kind 0 data, 1 end, 2 skip, 3 reset, 4 junk first word; model from the rules
  task automatic run(input int kind, input logic [15:0] seq, input logic [15:0] seg,
                     input bit bad);
    logic [15:0] first;
    logic [15:0] body[$];
    logic [37:0] ew[$];
    logic [7:0] ev;
    logic order;
    logic seq_ok;
    logic place;
    logic acc;
    first = (kind == 0) ? load_record_pkg::FIRST_DATA :
            (kind == 1) ? load_record_pkg::FIRST_END :
            (kind == 2) ? load_record_pkg::FIRST_SKIP :
            (kind == 3) ? load_record_pkg::FIRST_RESET : 16'h7302;
    body.push_back(seq);
    body.push_back(seg);
    if ((kind == 0) || (kind == 3))
      for (int k = 0; k < 16; k++)
        body.push_back(16'($random(seed)));
    order = (kind == 3) || m_active;
    seq_ok = (kind == 3) || ((kind == 2) ? (seq > m_last) : (seq == 16'(m_last + 16'h0001)));
    place = (kind != 0) || !(seg[11] || seg[10]);
    acc = !bad && order && seq_ok && place;
    if ((kind == 4) || ram_mode_in)
      ev = 8'h50;
    else
      ev = {acc && (kind == 1), 1'b0, acc, 1'b0, bad, order && !seq_ok, !order, !place};
    if (acc && (kind != 4) && !ram_mode_in)
    begin
      m_last = seq;
      if (kind == 3)
        m_active = 1'b1;
      if (kind == 1)
        m_active = 1'b0;
      if ((kind == 0) && (seg != load_record_pkg::SEG_SEQ_ONLY) && (seg[15:12] != 4'h0))
        for (int k = 0; k < 16; k++)
          ew.push_back({1'b0, seg[15:12], 1'b0, 16'({seg[9:0], 6'h00} + 2 * k), body[k + 2]});
    end
    i_sender.send(first, body, bad);
    repeat (20) @(posedge clk_in);
    #1;
    check_verdict(ev);
    check_writes(ew);
  endtask : run

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (5000) @(posedge clk_in);
    n_errors++;
    $display("mismatch %0t watchdog expired", $time);
    tally_and_finish();
  end

  // Scenarios
  initial
  begin
    ram_mode_in = 1'b0;
    nrst_in = 1'b0;
    repeat (5) @(posedge clk_in);
    #1;
    nrst_in = 1'b1;
    r = 16'($random(seed)) & 16'h0fff;
    run(0, 16'h0001, 16'h8000, 1'b0);
    run(3, r, 16'h1000, 1'b0);
    run(0, 16'(r + 1), {6'h3c, 10'($random(seed))}, 1'b0);
    run(0, 16'(r + 2), 16'h8010, 1'b1);
    run(0, 16'(r + 5), 16'h8010, 1'b0);
    run(0, 16'(r + 2), 16'h4800, 1'b0);
    run(0, 16'(r + 2), 16'h2400, 1'b0);
    for (int j = 0; j < 4; j++)
      run(0, 16'(r + 2 + j), (16'h8000 >> j) | {6'h00, 10'($random(seed))}, 1'b0);
    run(2, 16'(r + 9), 16'h0003, 1'b0);
    run(0, 16'(r + 10), 16'h1000, 1'b0);
    run(4, 16'(r + 11), 16'h0000, 1'b0);
    @(posedge clk_in);
    #1;
    ram_mode_in = 1'b1;
    run(0, 16'(r + 11), 16'h8000, 1'b0);
    ram_mode_in = 1'b0;
    run(1, 16'(r + 11), 16'h0005, 1'b0);
    run(0, 16'(r + 12), 16'h8000, 1'b0);
    // Second reset in mid-run
    nrst_in = 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    nrst_in = 1'b1;
    m_last = 16'h0000;
    m_active = 1'b0;
    @(negedge clk_in);
    check_idle();
    run(3, 16'(r + 20), 16'h0000, 1'b0);
    run(0, 16'(r + 21), 16'h0040, 1'b0);
    run(1, 16'(r + 22), 16'h0000, 1'b0);
    tally_and_finish();
  end
endmodule : memory_load_record_loader_tb_top

bind load_record_loader loader_sva i_sva
(
  .clk_in(clk_in),
  .nrst_in(nrst_in),
  .word_valid_in(word_valid_in),
  .word_start_in(word_start_in),
  .word_in(word_in),
  .ram_mode_in(ram_mode_in),
  .mem_write_out(mem_write_out),
  .mem_write_valid_out(mem_write_valid_out),
  .bank_select_out(bank_select_out),
  .result_out(result_out),
  .result_valid_out(result_valid_out),
  .invalid_command_out(invalid_command_out),
  .start_exec_out(start_exec_out),
  .load_active_out(load_active_out),
  .last_seq_out(last_seq_out)
);
`default_nettype wire
